// [verilog/fo_pkg.sv]
// Constants, field layout and helpers for the filter and orientation registers.
package fo_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] FO_ADDR_FILTER_CFG    = 8'h0F;
  localparam logic [7:0] FO_ADDR_ORIENT_STATUS = 8'h10;

  // ----------------------------------------------------------------------
  // Filter configuration fields
  // ----------------------------------------------------------------------
  localparam int         FO_HPF_BYP_BIT = 5;
  localparam int         FO_LPF_EN_BIT  = 4;
  localparam int         FO_SEL_LSB     = 0;
  localparam logic       FO_HPF_BYP_RST = 1'b0;
  localparam logic       FO_LPF_EN_RST  = 1'b0;
  localparam logic [1:0] FO_SEL_RST     = 2'h0;

  // ----------------------------------------------------------------------
  // Orientation status fields
  // ----------------------------------------------------------------------
  localparam int         FO_CHG_BIT   = 7;
  localparam int         FO_LOCK_BIT  = 6;
  localparam int         FO_CODE_LSB  = 1;
  localparam int         FO_BACK_BIT  = 0;
  localparam logic       FO_CHG_RST   = 1'b0;
  localparam logic       FO_LOCK_RST  = 1'b0;
  localparam logic [1:0] FO_CODE_RST  = 2'h0;
  localparam logic       FO_BACK_RST  = 1'b0;
  localparam logic       FO_FRONT     = 1'b0;
  localparam logic       FO_BACK      = 1'b1;
  localparam logic [1:0] FO_PORTRAIT_UP   = 2'h0;
  localparam logic [1:0] FO_PORTRAIT_DOWN = 2'h1;
  localparam logic [1:0] FO_LAND_RIGHT    = 2'h2;
  localparam logic [1:0] FO_LAND_LEFT     = 2'h3;

  // ----------------------------------------------------------------------
  // Oversampling modes and data rate indices
  // ----------------------------------------------------------------------
  localparam logic [1:0] FO_OS_NORMAL = 2'h0;
  localparam logic [1:0] FO_OS_LNLP   = 2'h1;
  localparam logic [1:0] FO_OS_HIRES  = 2'h2;
  localparam logic [1:0] FO_OS_LOWPWR = 2'h3;
  localparam logic [2:0] FO_ODR_800  = 3'h0;
  localparam logic [2:0] FO_ODR_400  = 3'h1;
  localparam logic [2:0] FO_ODR_200  = 3'h2;
  localparam logic [2:0] FO_ODR_100  = 3'h3;
  localparam logic [2:0] FO_ODR_50   = 3'h4;
  localparam logic [2:0] FO_ODR_12P5 = 3'h5;

  // Cutoff is reported as 16 Hz divided by two to the power of the shift.
  localparam int         FO_CUTOFF_BASE_HZ = 16;
  localparam int         FO_SHIFT_W        = 4;

  // ----------------------------------------------------------------------
  // Acceleration limit for the orientation lock
  // ----------------------------------------------------------------------
  localparam int          FO_AXIS_W        = 12;
  localparam logic [11:0] FO_LOCK_LIMIT_MG = 12'h4E2;

  function automatic logic fo_over_limit(input logic [FO_AXIS_W-1:0] mag_mg);
    return mag_mg > FO_LOCK_LIMIT_MG;
  endfunction

endpackage

// [verilog/fo_cutoff_lut.sv]
// High-pass cutoff lookup from data rate, oversampling mode and selector.
module fo_cutoff_lut
  import fo_pkg::*;
(
  input  wire logic [1:0]                    os_mode,
  input  wire logic [2:0]                    output_data_rate,
  input  wire logic [1:0]                    cutoff_sel,
  output logic      [fo_pkg::FO_SHIFT_W-1:0] cutoff_shift
);

  // ----------------------------------------------------------------------
  // Shift of the 00 code; each higher code halves once more
  // ----------------------------------------------------------------------
  function automatic logic [FO_SHIFT_W-1:0] base_shift(input logic [1:0] m,
                                                       input logic [2:0] r);
    logic [FO_SHIFT_W-1:0] s;
    s = 4'h0;
    case (m)
      FO_OS_HIRES: s = 4'h0;
      FO_OS_LOWPWR: begin
        if (r >= FO_ODR_12P5) s = 4'h6;
        else                  s = {1'b0, r};
      end
      default: begin
        if (r <= FO_ODR_400)                          s = 4'h0;
        else if (r >= FO_ODR_12P5 && m == FO_OS_LNLP) s = 4'h5;
        else if (r >= FO_ODR_50)                      s = 4'h3;
        else                                          s = {1'b0, r - 3'h1};
      end
    endcase
    return s;
  endfunction

  always_comb begin
    cutoff_shift = base_shift(os_mode, output_data_rate) + {2'h0, cutoff_sel};
  end

endmodule

// [verilog/fo_orient_track.sv]
// Holds the latest accepted orientation result and flags each change.
module fo_orient_track
  import fo_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       active_mode,
  input  wire logic       detect_enable,
  input  wire logic       over_limit,
  input  wire logic       det_valid,
  input  wire logic       det_lockout,
  input  wire logic [1:0] det_code,
  input  wire logic       det_back,
  output logic            tilt_lockout,
  output logic [1:0]      orientation_code,
  output logic            back_front_bit,
  output logic            change_q
);

  logic first_q;
  logic accept;
  logic differs;

  // The result freezes while any axis is above the limit.
  assign accept  = det_valid & detect_enable & active_mode & ~over_limit;
  assign differs = (det_lockout != tilt_lockout) | (det_code != orientation_code)
                 | (det_back != back_front_bit);

  // ----------------------------------------------------------------------
  // First detection after leaving standby
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      first_q <= 1'b1;
    end else if (!active_mode) begin
      first_q <= 1'b1;
    end else if (accept) begin
      first_q <= 1'b0;
    end
  end

  // Fields keep tracking even while the change flag is still pending.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tilt_lockout     <= FO_LOCK_RST;
      orientation_code <= FO_CODE_RST;
      back_front_bit   <= FO_BACK_RST;
    end else if (accept) begin
      tilt_lockout     <= det_lockout;
      orientation_code <= det_code;
      back_front_bit   <= det_back;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      change_q <= 1'b0;
    end else begin
      change_q <= accept & (first_q | differs);
    end
  end

endmodule

// [verilog/fo_filter_orient_regs.sv]
// Filter configuration and orientation status register slice.
//
// How it works
// - Filter register bit 5 bypasses pulse high-pass when 1; resets 0.
// - Filter register bit 4 enables pulse low-pass when 1; resets 0.
// - Bits 1:0 select cutoff, reset 00; bits 7:6 and 3:2 read zero.
// - High-resolution mode gives 16, 8, 4, 2 Hz at every rate.
// - Normal mode gives 16 Hz at 800 and 400, then halves per rate down to 2 Hz.
// - Low-noise low-power matches normal, then 0.5 Hz base below 50 Hz.
// - Low-power mode halves per rate step, 16 Hz down to 0.25 Hz base.
// - Status holds change flag 7, lockout 6, code 2:1, back 0.
// - Change flag sets on first detection after activation or any change.
// - Reading the status register clears the change flag and interrupt.
// - Lockout bit reads 1 once the tilt trip angle is exceeded.
// - Code 00 portrait up, 01 down, 10 landscape right, 11 left.
// - Back/front bit is 0 for front, 1 for back.
// - All status fields and the change flag start at zero.
// - Fields keep updating while the change flag is set.
// - Result holds while any axis exceeds 1.25 g.
// - Interrupt status sets with the flag when enabled; read clears it.
// - Detection runs only while its enable is 1.
module fo_filter_orient_regs
  import fo_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         active_mode,
  input  wire logic                         orientation_detect_enable,
  input  wire logic                         orientation_irq_enable,
  input  wire logic [1:0]                   os_mode,
  input  wire logic [2:0]                   output_data_rate,
  input  wire logic [fo_pkg::FO_AXIS_W-1:0] axis_x_mg,
  input  wire logic [fo_pkg::FO_AXIS_W-1:0] axis_y_mg,
  input  wire logic [fo_pkg::FO_AXIS_W-1:0] axis_z_mg,
  input  wire logic                         det_valid,
  input  wire logic                         det_lockout,
  input  wire logic [1:0]                   det_code,
  input  wire logic                         det_back,
  output logic      [7:0]                   reg_rdata,
  output logic                              pulse_highpass_bypass,
  output logic                              pulse_lowpass_enable,
  output logic      [1:0]                   cutoff_sel,
  output logic      [fo_pkg::FO_SHIFT_W-1:0] cutoff_shift,
  output logic                              orientation_change_flag,
  output logic                              orientation_irq_status
);

  import fo_pkg::*;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic       wr_filter;
  logic       rd_filter;
  logic       rd_status;
  logic       over_limit;
  logic       change;
  logic       tilt_lockout;
  logic [1:0] orientation_code;
  logic       back_front_bit;
  logic [FO_SHIFT_W-1:0] cutoff_shift_d;
  logic [7:0] filter_byte;
  logic [7:0] status_byte;

  always_comb begin
    wr_filter = 1'b0;
    rd_filter = 1'b0;
    rd_status = 1'b0;
    if (reg_addr == FO_ADDR_FILTER_CFG) begin
      wr_filter = reg_wr;
      rd_filter = reg_rd;
    end else if (reg_addr == FO_ADDR_ORIENT_STATUS) begin
      // Writes here fall through on purpose; the register is read-only.
      rd_status = reg_rd;
    end
  end

  assign over_limit = fo_over_limit(axis_x_mg) | fo_over_limit(axis_y_mg)
                    | fo_over_limit(axis_z_mg);

  // ----------------------------------------------------------------------
  // Orientation result and cutoff lookup
  // ----------------------------------------------------------------------
  fo_orient_track u_track (
    .clk_sys          (clk_sys),
    .nrst             (nrst),
    .active_mode      (active_mode),
    .detect_enable    (orientation_detect_enable),
    .over_limit       (over_limit),
    .det_valid        (det_valid),
    .det_lockout      (det_lockout),
    .det_code         (det_code),
    .det_back         (det_back),
    .tilt_lockout     (tilt_lockout),
    .orientation_code (orientation_code),
    .back_front_bit   (back_front_bit),
    .change_q         (change)
  );

  fo_cutoff_lut u_lut (
    .os_mode          (os_mode),
    .output_data_rate (output_data_rate),
    .cutoff_sel       (cutoff_sel),
    .cutoff_shift     (cutoff_shift_d)
  );

  // ----------------------------------------------------------------------
  // Filter configuration register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pulse_highpass_bypass <= FO_HPF_BYP_RST;
      pulse_lowpass_enable  <= FO_LPF_EN_RST;
      cutoff_sel            <= FO_SEL_RST;
    end else if (wr_filter) begin
      pulse_highpass_bypass <= reg_wdata[FO_HPF_BYP_BIT];
      pulse_lowpass_enable  <= reg_wdata[FO_LPF_EN_BIT];
      cutoff_sel            <= reg_wdata[FO_SEL_LSB+1:FO_SEL_LSB];
    end
  end

  // The shift lags the selector by one cycle so that the output is a flop.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cutoff_shift <= '0;
    end else begin
      cutoff_shift <= cutoff_shift_d;
    end
  end

  // ----------------------------------------------------------------------
  // Change flag and interrupt status
  // ----------------------------------------------------------------------
  // A change in the same cycle as the clearing read wins, so no event is lost.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      orientation_change_flag <= FO_CHG_RST;
    end else if (change) begin
      orientation_change_flag <= 1'b1;
    end else if (rd_status) begin
      orientation_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      orientation_irq_status <= 1'b0;
    end else if (change && orientation_irq_enable) begin
      orientation_irq_status <= 1'b1;
    end else if (rd_status) begin
      orientation_irq_status <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    filter_byte = 8'h00;
    filter_byte[FO_HPF_BYP_BIT] = pulse_highpass_bypass;
    filter_byte[FO_LPF_EN_BIT]  = pulse_lowpass_enable;
    filter_byte[FO_SEL_LSB+1:FO_SEL_LSB] = cutoff_sel;
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[FO_CHG_BIT]  = orientation_change_flag;
    status_byte[FO_LOCK_BIT] = tilt_lockout;
    status_byte[FO_CODE_LSB+1:FO_CODE_LSB] = orientation_code;
    status_byte[FO_BACK_BIT] = back_front_bit;
  end

  // The read returns the value seen before the clear takes effect.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (rd_status) begin
      reg_rdata <= status_byte;
    end else if (rd_filter) begin
      reg_rdata <= filter_byte;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_flag_sets_change: assert property (
    change |=> orientation_change_flag)
    else $error("change flag did not set after a change");

  a_flag_read_clear: assert property (
    rd_status && !change |=> !orientation_change_flag ##1 !$rose(reg_rdata[FO_CHG_BIT]))
    else $error("change flag not cleared by status read");

  a_flag_holds_idle: assert property (
    !rd_status && !change |=> $stable(orientation_change_flag))
    else $error("change flag moved without cause");

  a_irq_follows_flag: assert property (
    $rose(orientation_irq_status) |-> $past(change && orientation_irq_enable)
      && orientation_change_flag)
    else $error("interrupt status rose without an enabled change");

  a_irq_read_clear: assert property (
    rd_status && !change |=> !orientation_irq_status && !orientation_change_flag)
    else $error("interrupt status not cleared by status read");

  a_cfg_write_takes: assert property (
    wr_filter |=> pulse_highpass_bypass == $past(reg_wdata[FO_HPF_BYP_BIT])
      && pulse_lowpass_enable == $past(reg_wdata[FO_LPF_EN_BIT])
      && cutoff_sel == $past(reg_wdata[1:0]))
    else $error("filter configuration write not stored");

  a_cfg_no_write: assert property (
    !wr_filter |=> $stable(cutoff_sel) && $stable(pulse_lowpass_enable)
      && $stable(pulse_highpass_bypass))
    else $error("filter configuration changed without a write");

  a_filter_reserved: assert property (
    rd_filter |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0)
    else $error("filter register reserved bits not zero");

  a_status_readback: assert property (
    rd_status |=> reg_rdata == $past(status_byte) && reg_rdata[5:3] == 3'h0)
    else $error("status read data wrong");

  a_status_read_only: assert property (
    reg_wr && reg_addr == FO_ADDR_ORIENT_STATUS && !change && !rd_status && !det_valid
      |=> $stable(status_byte))
    else $error("status register altered by a write");

  a_hold_overload: assert property (
    over_limit |=> $stable(orientation_code) && $stable(tilt_lockout)
      && $stable(back_front_bit) && !change)
    else $error("orientation moved above the acceleration limit");

  a_disabled_quiet: assert property (
    !orientation_detect_enable |=> !change && $stable(orientation_code))
    else $error("orientation changed while detection disabled");

  a_track_while_set: assert property (
    det_valid && orientation_detect_enable && active_mode && !over_limit
      && orientation_change_flag |=> orientation_code == $past(det_code)
      && back_front_bit == $past(det_back))
    else $error("fields frozen while change flag set");

  a_hires_cutoff: assert property (
    os_mode == FO_OS_HIRES ##1 os_mode == FO_OS_HIRES && $stable(cutoff_sel)
      |=> cutoff_shift == {2'h0, $past(cutoff_sel)})
    else $error("high resolution cutoff wrong");

  a_lowpwr_floor: assert property (
    os_mode == FO_OS_LOWPWR && output_data_rate >= FO_ODR_12P5
      |=> cutoff_shift == 4'h6 + {2'h0, $past(cutoff_sel)})
    else $error("low power cutoff floor wrong");

  a_lnlp_floor: assert property (
    os_mode == FO_OS_LNLP && output_data_rate >= FO_ODR_12P5
      |=> cutoff_shift == 4'h5 + {2'h0, $past(cutoff_sel)})
    else $error("low noise cutoff floor wrong");

  a_normal_floor: assert property (
    os_mode == FO_OS_NORMAL && output_data_rate >= FO_ODR_50
      |=> cutoff_shift == 4'h3 + {2'h0, $past(cutoff_sel)})
    else $error("normal mode cutoff floor wrong");

  a_first_after_wake: assert property (
    !active_mode ##1 active_mode && det_valid && orientation_detect_enable
      && !over_limit |=> change ##1 orientation_change_flag)
    else $error("first detection after activation not flagged");

  a_result_loads: assert property (
    det_valid && orientation_detect_enable && active_mode && !over_limit
      |=> tilt_lockout == $past(det_lockout) && orientation_code == $past(det_code)
      && back_front_bit == $past(det_back))
    else $error("accepted orientation result not stored");

  a_lockout_readback: assert property (
    rd_status |=> reg_rdata[FO_LOCK_BIT] == $past(tilt_lockout))
    else $error("lockout bit wrong in status read");

  a_code_readback: assert property (
    rd_status |=> reg_rdata[FO_CODE_LSB+1:FO_CODE_LSB] == $past(orientation_code))
    else $error("orientation code wrong in status read");

  a_back_readback: assert property (
    rd_status |=> reg_rdata[FO_BACK_BIT] == $past(back_front_bit))
    else $error("back/front bit wrong in status read");

  a_reset_clean: assert property (
    $rose(nrst) |-> orientation_change_flag == FO_CHG_RST && !orientation_irq_status
      && tilt_lockout == FO_LOCK_RST && orientation_code == FO_CODE_RST
      && back_front_bit == FO_BACK_RST)
    else $error("status not clear after reset");

  a_change_has_cause: assert property (
    change |-> $past(det_valid && orientation_detect_enable && active_mode && !over_limit))
    else $error("change pulse without an accepted result");

  a_irq_sets: assert property (
    change && orientation_irq_enable |=> orientation_irq_status)
    else $error("interrupt status missed an enabled change");

  a_irq_masked: assert property (
    !orientation_irq_enable && !orientation_irq_status |=> !orientation_irq_status)
    else $error("interrupt status set while disabled");

  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  a_unmapped_zero: assert property (
    reg_rd && !rd_status && !rd_filter |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  a_filter_readback: assert property (
    rd_filter |=> reg_rdata[FO_HPF_BYP_BIT] == $past(pulse_highpass_bypass)
      && reg_rdata[FO_LPF_EN_BIT] == $past(pulse_lowpass_enable)
      && reg_rdata[FO_SEL_LSB+1:FO_SEL_LSB] == $past(cutoff_sel))
    else $error("filter register read data wrong");

  a_normal_steps: assert property (
    os_mode == FO_OS_NORMAL && output_data_rate == FO_ODR_200
      |=> cutoff_shift == 4'h1 + {2'h0, $past(cutoff_sel)})
    else $error("normal mode cutoff at mid rate wrong");

  a_lowpwr_steps: assert property (
    os_mode == FO_OS_LOWPWR && output_data_rate == FO_ODR_50
      |=> cutoff_shift == 4'h4 + {2'h0, $past(cutoff_sel)})
    else $error("low power cutoff at mid rate wrong");

  a_fast_rates: assert property (
    (os_mode == FO_OS_NORMAL || os_mode == FO_OS_LNLP) && output_data_rate <= FO_ODR_400
      |=> cutoff_shift == {2'h0, $past(cutoff_sel)})
    else $error("cutoff at fast rates wrong");

endmodule

// [sim/fo_host_model.sv]
// Host model that reaches the filter and orientation registers over the byte port.
module fo_host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // A normal host aims its writes at the filter register only.
  // Address and data are inverted once the strobe drops, so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// [sim/fo_filter_orient_regs_tb.sv]
// Self-checking testbench for the filter and orientation register slice.
module fo_filter_orient_regs_tb
  import fo_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_sys, nrst, active_mode, orientation_detect_enable;
  logic                  orientation_irq_enable, reg_wr, reg_rd, det_valid, det_lockout;
  logic                  det_back, rd_q, pulse_highpass_bypass, pulse_lowpass_enable;
  logic                  orientation_change_flag, orientation_irq_status;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0]            os_mode, det_code, cutoff_sel;
  logic [2:0]            output_data_rate;
  logic [FO_AXIS_W-1:0]  axis_x_mg, axis_y_mg, axis_z_mg;
  logic [FO_SHIFT_W-1:0] cutoff_shift;
  logic [7:0]            exp_q[$];
  int                    num_errors = 0;
  int                    checked = 0;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  fo_host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  fo_filter_orient_regs dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .active_mode(active_mode),
    .orientation_detect_enable(orientation_detect_enable),
    .orientation_irq_enable(orientation_irq_enable), .os_mode(os_mode),
    .output_data_rate(output_data_rate), .axis_x_mg(axis_x_mg), .axis_y_mg(axis_y_mg),
    .axis_z_mg(axis_z_mg), .det_valid(det_valid), .det_lockout(det_lockout),
    .det_code(det_code), .det_back(det_back), .reg_rdata(reg_rdata),
    .pulse_highpass_bypass(pulse_highpass_bypass), .pulse_lowpass_enable(pulse_lowpass_enable),
    .cutoff_sel(cutoff_sel), .cutoff_shift(cutoff_shift),
    .orientation_change_flag(orientation_change_flag),
    .orientation_irq_status(orientation_irq_status));

  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t ns: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    host_u.rd(a);
  endtask

  task automatic flg(input logic f, input logic i);
    chk({7'h00, orientation_change_flag}, {7'h00, f}, "change flag");
    chk({7'h00, orientation_irq_status}, {7'h00, i}, "irq status");
  endtask

  // One-cycle detection pulse; returns once the flag has had time to land.
  task automatic det(input logic [3:0] k);
    @(negedge clk_sys);
    det_valid = 1'b1;
    det_lockout = k[3];
    det_code = k[2:1];
    det_back = k[0];
    @(negedge clk_sys);
    det_valid = 1'b0;
    det_code = ~k[2:1];
    det_back = ~k[0];
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  function automatic logic [7:0] st(input logic f, input logic [3:0] k);
    return {f, k[3], 3'b000, k[2:1], k[0]};
  endfunction

  function automatic logic [3:0] exp_shift(input int m, input int r, input int s);
    int b;
    if (m == 2) b = 0;
    else if (m == 3) b = (r >= 5) ? 6 : r;
    else if (m == 1 && r >= 5) b = 5;
    else b = (r == 0) ? 0 : (r >= 4) ? 3 : r - 1;
    return 4'(b + s);
  endfunction

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rd_q <= 1'b0;
    else rd_q <= reg_rd;
  end

  always @(negedge clk_sys) begin
    if (rd_q) chk(reg_rdata, exp_q.pop_front(), "read data");
  end

  initial begin
    #(50000 * 40);
    num_errors++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    conclude();
  end

  initial begin
    {nrst, active_mode, det_valid, det_lockout, det_code, det_back} = '0;
    {orientation_detect_enable, orientation_irq_enable} = 2'b11;
    {os_mode, output_data_rate, axis_x_mg, axis_y_mg, axis_z_mg} = '0;
    void'($urandom(75894));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) nrst = 1'b1;
    flg(1'b0, 1'b0);
    rdx(FO_ADDR_FILTER_CFG, 8'h00);
    rdx(FO_ADDR_ORIENT_STATUS, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'hCC : 8'($urandom);
      host_u.wr(FO_ADDR_FILTER_CFG, d);
      chk({2'b00, pulse_highpass_bypass, pulse_lowpass_enable, 2'b00, cutoff_sel},
          d & 8'h33, "config outputs");
      rdx(FO_ADDR_FILTER_CFG, d & 8'h33);
    end
    host_u.wr(FO_ADDR_ORIENT_STATUS, 8'hFF);
    host_u.wr(8'h27, 8'hAA);
    rdx(FO_ADDR_ORIENT_STATUS, 8'h00);
    rdx(8'h27, 8'h00);
    rdx(FO_ADDR_FILTER_CFG, d & 8'h33);
    flg(1'b0, 1'b0);
    $display("test register access done");
    for (int s = 0; s < 4; s++) begin
      host_u.wr(FO_ADDR_FILTER_CFG, 8'(s));
      for (int m = 0; m < 4; m++) begin
        for (int r = 0; r < 8; r++) begin
          @(negedge clk_sys);
          os_mode = 2'(m);
          output_data_rate = 3'(r);
          @(negedge clk_sys);
          chk(8'(cutoff_shift), 8'(exp_shift(m, r, s)), "cut");
        end
      end
    end
    $display("test cutoff done");
    @(negedge clk_sys) active_mode = 1'b1;
    for (int k = 0; k < 16; k++) begin
      det(4'(k));
      flg(1'b1, 1'b1);
      rdx(FO_ADDR_ORIENT_STATUS, st(1'b1, 4'(k)));
      flg(1'b0, 1'b0);
    end
    det(4'hF);
    flg(1'b0, 1'b0);
    det(4'h5);
    det(4'h6);
    rdx(FO_ADDR_ORIENT_STATUS, st(1'b1, 4'h6));
    axis_y_mg = 12'h4E3;
    det(4'h9);
    flg(1'b0, 1'b0);
    rdx(FO_ADDR_ORIENT_STATUS, st(1'b0, 4'h6));
    axis_y_mg = 12'h4E2;
    det(4'h9);
    rdx(FO_ADDR_ORIENT_STATUS, st(1'b1, 4'h9));
    axis_x_mg = 12'hFFF;
    det(4'h2);
    {axis_x_mg, axis_z_mg} = {12'h000, 12'h4E3};
    det(4'h2);
    flg(1'b0, 1'b0);
    rdx(FO_ADDR_ORIENT_STATUS, st(1'b0, 4'h9));
    {axis_y_mg, axis_z_mg} = '0;
    orientation_detect_enable = 1'b0;
    det(4'h3);
    flg(1'b0, 1'b0);
    orientation_detect_enable = 1'b1;
    orientation_irq_enable = 1'b0;
    det(4'h3);
    flg(1'b1, 1'b0);
    rdx(FO_ADDR_ORIENT_STATUS, st(1'b1, 4'h3));
    orientation_irq_enable = 1'b1;
    active_mode = 1'b0;
    det(4'h4);
    flg(1'b0, 1'b0);
    fork
      det(4'h3);
      @(negedge clk_sys) active_mode = 1'b1;
    join
    flg(1'b1, 1'b1);
    rdx(FO_ADDR_ORIENT_STATUS, st(1'b1, 4'h3));
    $display("test orientation done");
    conclude();
  end
endmodule
